// >>> dv/spi_ee_checker.sv
`default_nettype none
module spi_ee_checker #(
  parameter int WR_CYCLES = 400
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_so,
  input wire logic i_so_oe,
  input wire logic i_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] busy_cnt_q;
  logic [19:0] busy_cnt_d;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  always_comb begin
    busy_cnt_d = i_busy ? busy_cnt_q + 20'h00001 : 20'h00000;
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_cnt_q <= 20'h00000;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  idle_clk_low_a: assert property (i_cs_n |-> !i_sck)
    else $error("serial clock high while deselected");
  select_lead_a: assert property ($fell(i_cs_n) |-> !i_sck [*4])
    else $error("serial clock rose too soon after select");
  clk_high_len_a: assert property (
    $rose(i_sck) |-> i_sck [*4] ##1 !i_sck)
    else $error("serial clock high phase not four cycles");
  si_stable_a: assert property (
    i_sck && $past(i_sck) |-> $stable(i_si))
    else $error("data in moved while clock high");
  // Pin synchroniser puts the output change five cycles after the fall,
  // inside the high phase; the host samples at the next fall
  so_on_fall_a: assert property (
    i_so_oe && $past(i_so_oe) && $changed(i_so) |->
      !$past(i_sck, 5) && $past(i_sck, 6))
    else $error("data out moved away from a clock fall");
  first_out_a: assert property ($rose(i_so_oe) |->
    !i_cs_n && !$past(i_sck, 5) && $past(i_sck, 6))
    else $error("output enabled away from a clock fall");
  out_release_a: assert property (i_cs_n [*7] |-> !i_so_oe)
    else $error("output still driven after deselect");
  busy_launch_a: assert property (
    $rose(i_busy) |-> i_cs_n && $past(i_cs_n, 3))
    else $error("write cycle launched while selected");
  busy_ones_a: assert property (i_busy && i_so_oe |-> i_so)
    else $error("status bit zero while busy");
  busy_len_a: assert property ($fell(i_busy) |->
    busy_cnt_q >= WR_CYCLES - 1 && busy_cnt_q <= WR_CYCLES + 1)
    else $error("write cycle length wrong");
  cover property ($rose(i_busy));
  cover property (i_busy && i_so_oe);
  cover property ($rose(i_so_oe));
endmodule
`default_nettype wire

// >>> dv/tb_serial_eeprom_status_read_ctrl.sv
`default_nettype none
module tb_serial_eeprom_status_read_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_ee_pkg::*;
  // Short write cycle, still longer than a busy-time status read
  localparam int WR_CYC = 400;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic fac_nrst = 1'b0;
  logic lock_n = 1'b1;
  logic start = 1'b0;
  logic [7:0] opc = 8'h00;
  logic [15:0] adr = 16'h0000;
  logic [7:0] wd = 8'h00;
  logic [7:0] nb = 8'h00;
  logic ready;
  logic rvalid;
  logic done;
  logic busy;
  logic [7:0] rdata;
  logic [7:0] rx[$];
  logic [7:0] mdl [0:2047];
  logic [10:0] corner [6] = '{11'h000, 11'h3ff, 11'h400, 11'h5ff, 11'h600,
                              11'h7ff};
  logic [7:0] rnd = 8'h3f;
  logic [10:0] a;
  logic [7:0] d;
  int err_total = 0;
  int check_count = 0;
  spi_ee_if lnk();
  always #10 i_clk_sys = ~i_clk_sys;
  spi_ee_host spi_ee_host_inst (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_start(start),
    .i_opcode(opc),
    .i_addr(adr),
    .i_wdata(wd),
    .i_nbytes(nb),
    .o_ready(ready),
    .o_rdata(rdata),
    .o_rvalid(rvalid),
    .o_done(done),
    .link(lnk)
  );
  spi_ee_dev #(.WR_CYCLES(WR_CYC)) spi_ee_dev_inst (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_factory_nrst(fac_nrst),
    .i_lock_pin_n(lock_n),
    .o_busy(busy),
    .link(lnk)
  );
  spi_ee_checker #(.WR_CYCLES(WR_CYC)) spi_ee_checker_inst (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_cs_n(lnk.cs_n),
    .i_sck(lnk.sck),
    .i_si(lnk.si),
    .i_so(lnk.so),
    .i_so_oe(lnk.so_oe),
    .i_busy(busy)
  );
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic guarded(input logic [1:0] g, input logic [10:0] x);
    case (g)
      2'h1: return x >= 11'h600;
      2'h2: return x >= 11'h400;
      2'h3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [7:0] op, input logic [15:0] ad,
                       input logic [7:0] dt, input logic [7:0] n);
    int i;
    rx.delete();
    @(negedge i_clk_sys);
    opc = op;
    adr = ad;
    wd = dt;
    nb = n;
    start = 1'b1;
    @(negedge i_clk_sys);
    start = 1'b0;
    check({7'h00, ready}, 8'h00);
    for (i = 0; i < 2000 && done !== 1'b1; i++) begin
      @(negedge i_clk_sys);
      if (rvalid === 1'b1) begin
        rx.push_back(rdata);
      end
    end
    if (i == 2000) begin
      err_total++;
      report_and_stop();
    end
    check({7'h00, ready}, 8'h01);
  endtask
  task automatic st(input logic [7:0] n);
    frame(OPC_RDST, 16'h0000, 8'h00, n);
  endtask
  // Launch lags the select rise, so let it land before polling
  task automatic wait_idle();
    int i;
    repeat (8) @(negedge i_clk_sys);
    for (i = 0; i < 1000 && busy !== 1'b0; i++) begin
      @(negedge i_clk_sys);
    end
    if (i == 1000) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic wst(input logic [7:0] v);
    frame(OPC_SETWL, 16'h0000, 8'h00, 8'h00);
    frame(OPC_WRST, 16'h0000, v, 8'h00);
    wait_idle();
  endtask
  initial begin
    foreach (mdl[k]) mdl[k] = 8'h00;
    repeat (10) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    fac_nrst = 1'b1;
    st(8'h01);
    check(rx[0], 8'h00);
    frame(OPC_SETWL, 16'h0000, 8'h00, 8'h00);
    st(8'h01);
    check(rx[0], 8'h02);
    frame(OPC_CLRWL, 16'h0000, 8'h00, 8'h00);
    frame(OPC_WRST, 16'h0000, 8'hfc, 8'h00);
    wait_idle();
    st(8'h01);
    check(rx[0], 8'h00);
    frame(OPC_SETWL, 16'h0000, 8'h00, 8'h00);
    frame(OPC_WRST, 16'h0000, 8'hfc, 8'h00);
    // Latch set attempt while busy must be dropped
    frame(OPC_SETWL, 16'h0000, 8'h00, 8'h00);
    st(8'h02);
    check(rx[0], 8'hff);
    check(rx[1], 8'hff);
    wait_idle();
    st(8'h03);
    for (int k = 0; k < 3; k++) check(rx[k], 8'h8c);
    lock_n = 1'b0;
    wst(8'h00);
    st(8'h01);
    check(rx[0], 8'h8e);
    frame(OPC_WRARR, 16'h0123, 8'h5a, 8'h00);
    wait_idle();
    frame(OPC_RDARR, 16'h0123, 8'h00, 8'h01);
    check(rx[0], 8'h00);
    lock_n = 1'b1;
    for (int g = 0; g < 4; g++) begin
      wst({1'b0, 3'h7, g[1:0], 2'h3});
      st(8'h01);
      check(rx[0], {4'h0, g[1:0], 2'h0});
      foreach (corner[j]) begin
        a = corner[j];
        rnd = lfsr(rnd);
        d = rnd;
        rnd = lfsr(rnd);
        frame(OPC_SETWL, 16'h0000, 8'h00, 8'h00);
        frame(OPC_WRARR, {rnd[4:0], a}, d, 8'h00);
        wait_idle();
        if (!guarded(g[1:0], a)) begin
          mdl[a] = d;
        end
        frame(OPC_RDARR, {rnd[7:3], a}, 8'h00, 8'h02);
        check(rx[0], mdl[a]);
        check(rx[1], mdl[a + 11'h001]);
        st(8'h01);
        check(rx[0], {4'h0, g[1:0], 2'h0});
      end
    end
    // Power-on reset again: guard bits must survive it
    i_nrst = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    st(8'h01);
    check(rx[0], 8'h0c);
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> hw/pin_sync.sv
`default_nettype none
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic [2:0] sh_q, sh_d;
  logic lvl_q, lvl_d, rise_q, rise_d, fall_q, fall_d;

  // Change counts only once second and third stage agree
  always_comb begin
    sh_d = {sh_q[1:0], i_pin};
    lvl_d = lvl_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (sh_q[1] == sh_q[2]) begin
      lvl_d = sh_q[2];
      rise_d = sh_q[2] & ~lvl_q;
      fall_d = ~sh_q[2] & lvl_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sh_q <= {3{RST_VAL}};
      lvl_q <= RST_VAL;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign o_level = lvl_q;
  assign o_rise = rise_q;
  assign o_fall = fall_q;
endmodule
`default_nettype wire

// >>> hw/spi_ee_dev.sv
`default_nettype none
module spi_ee_dev #(
  parameter int WR_CYCLES = spi_ee_pkg::WR_CYCLE_CLKS
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_factory_nrst,
  input wire logic i_lock_pin_n,
  output logic o_busy,
  spi_ee_if.dev link
);
  import spi_ee_pkg::*;

  typedef enum logic [2:0] {S_OPC, S_ADDR, S_WDATA, S_OUT, S_SKIP} dstate_t;

  logic cs_lvl, cs_rise, sck_rise, sck_fall, si_lvl, lock_lvl;
  dstate_t st_q, st_d;
  cmd_t cmd_q, cmd_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] rx_q, rx_d, wbyte_q, wbyte_d, osr_q, osr_d, pend_q, pend_d;
  logic [10:0] addr_q, addr_d;
  logic [2:0] obit_q, obit_d;
  logic have_q, have_d, so_q, so_d, oe_q, oe_d, wel_q, wel_d;
  logic busy_q, busy_d, parr_q, parr_d, wrok_q, wrok_d, pin_lock_enable_q, pin_lock_enable_d;
  logic [1:0] guard_q, guard_d;
  logic [17:0] wcnt_q, wcnt_d;
  logic [7:0] mem_q [0:ARR_DEPTH-1];
  logic mem_we, hw_prot;
  logic [7:0] stat, op, obyte;

  pin_sync #(.RST_VAL(1'b1)) u_cs (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_pin(link.cs_n), .o_level(cs_lvl), .o_rise(cs_rise), .o_fall());
  pin_sync #(.RST_VAL(1'b0)) u_sck (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_pin(link.sck), .o_level(), .o_rise(sck_rise), .o_fall(sck_fall));
  pin_sync #(.RST_VAL(1'b0)) u_si (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_pin(link.si), .o_level(si_lvl), .o_rise(), .o_fall());
  pin_sync #(.RST_VAL(1'b1)) u_lock (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_pin(i_lock_pin_n), .o_level(lock_lvl), .o_rise(), .o_fall());

  function automatic cmd_t decode(input logic [7:0] opc, input logic busy);
    logic [7:0] m;
    m = opc & OPC_MASK;
    decode = CMD_NONE;
    if (m == OPC_RDST) decode = CMD_RDST;
    else if (busy) decode = CMD_NONE;
    else if (m == OPC_SETWL) decode = CMD_SETWL;
    else if (m == OPC_CLRWL) decode = CMD_CLRWL;
    else if (m == OPC_WRST) decode = CMD_WRST;
    else if (m == OPC_RDARR) decode = CMD_RDARR;
    else if (m == OPC_WRARR) decode = CMD_WRARR;
  endfunction

  function automatic logic guarded(input logic [10:0] a, input logic [1:0] g);
    unique case (g)
      2'h0: guarded = 1'b0;
      2'h1: guarded = (a >= GUARD_QTR_BASE);
      2'h2: guarded = (a >= GUARD_HALF_BASE);
      2'h3: guarded = 1'b1;
    endcase
  endfunction

  assign hw_prot = pin_lock_enable_q & ~lock_lvl;

  always_comb begin
    // Bits 4..6 are never stored and read zero when idle
    stat = 8'h00;
    stat[ST_NRDY] = 1'b0;
    stat[ST_WEL] = wel_q;
    stat[ST_GUARD_LO] = guard_q[0];
    stat[ST_GUARD_HI] = guard_q[1];
    stat[ST_PINLOCK] = pin_lock_enable_q;
    if (busy_q) stat = ST_BUSY_VAL;
  end

  always_comb begin
    op = {rx_q[6:0], si_lvl};
    obyte = (cmd_q == CMD_RDST) ? stat : mem_q[addr_q];
    st_d = st_q;
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    rx_d = rx_q;
    addr_d = addr_q;
    wbyte_d = wbyte_q;
    have_d = have_q;
    obit_d = obit_q;
    osr_d = osr_q;
    so_d = so_q;
    oe_d = oe_q;
    wel_d = wel_q;
    busy_d = busy_q;
    wcnt_d = wcnt_q;
    pend_d = pend_q;
    parr_d = parr_q;
    wrok_d = wrok_q;
    guard_d = guard_q;
    pin_lock_enable_d = pin_lock_enable_q;
    mem_we = 1'b0;
    if (cs_lvl) begin
      st_d = S_OPC;
      cmd_d = CMD_NONE;
      cnt_d = 4'h0;
      obit_d = 3'h0;
      oe_d = 1'b0;
      have_d = 1'b0;
    end else if (sck_rise) begin
      rx_d = op;
      cnt_d = cnt_q + 4'h1;
      unique case (st_q)
        S_OPC: if (cnt_q == 4'h7) begin
          cmd_d = decode(op, busy_q);
          cnt_d = 4'h0;
          unique case (cmd_d)
            CMD_RDST: st_d = S_OUT;
            CMD_RDARR, CMD_WRARR: st_d = S_ADDR;
            CMD_WRST: st_d = S_WDATA;
            // Undefined opcodes fall to skip: frame has no effect
            default: st_d = S_SKIP;
          endcase
        end
        S_ADDR: begin
          // Upper address bits shift out of the 11-bit register
          addr_d = {addr_q[9:0], si_lvl};
          if (cnt_q == 4'hf) begin
            cnt_d = 4'h0;
            st_d = (cmd_q == CMD_RDARR) ? S_OUT : S_WDATA;
          end
        end
        S_WDATA: if (cnt_q == 4'h7) begin
          cnt_d = 4'h0;
          wbyte_d = op;
          have_d = 1'b1;
        end
        S_OUT, S_SKIP: cnt_d = 4'h0;
      endcase
    end else if (sck_fall && st_q == S_OUT) begin
      oe_d = 1'b1;
      obit_d = obit_q + 3'h1;
      if (obit_q == 3'h0) begin
        // Reload each byte: status read repeats, live value
        so_d = obyte[7];
        osr_d = {obyte[6:0], 1'b0};
        if (cmd_q == CMD_RDARR) addr_d = addr_q + 11'h001;
      end else begin
        so_d = osr_q[7];
        osr_d = {osr_q[6:0], 1'b0};
      end
    end
    if (cs_rise && !busy_q) begin
      unique case (cmd_q)
        CMD_SETWL: wel_d = 1'b1;
        CMD_CLRWL: wel_d = 1'b0;
        CMD_WRST: if (have_q && wel_q && !hw_prot) begin
          busy_d = 1'b1;
          wcnt_d = 18'(WR_CYCLES - 1);
          pend_d = wbyte_q;
          parr_d = 1'b0;
        end
        CMD_WRARR: if (have_q && wel_q) begin
          busy_d = 1'b1;
          wcnt_d = 18'(WR_CYCLES - 1);
          parr_d = 1'b1;
          wrok_d = ~guarded(addr_q, guard_q);
        end
        default: ;
      endcase
    end else if (busy_q) begin
      wcnt_d = wcnt_q - 18'h00001;
      if (wcnt_q == 18'h00000) begin
        busy_d = 1'b0;
        wel_d = 1'b0;
        if (parr_q) begin
          mem_we = wrok_q;
        end else begin
          // Only guard and pin-lock bits are kept, at cycle end
          guard_d = {pend_q[ST_GUARD_HI], pend_q[ST_GUARD_LO]};
          pin_lock_enable_d = pend_q[ST_PINLOCK] | (pin_lock_enable_q & ~lock_lvl);
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= S_OPC;
      cmd_q <= CMD_NONE;
      cnt_q <= 4'h0;
      rx_q <= 8'h00;
      addr_q <= 11'h000;
      wbyte_q <= 8'h00;
      have_q <= 1'b0;
      obit_q <= 3'h0;
      osr_q <= 8'h00;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      wcnt_q <= 18'h00000;
      pend_q <= 8'h00;
      parr_q <= 1'b0;
      wrok_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      addr_q <= addr_d;
      wbyte_q <= wbyte_d;
      have_q <= have_d;
      obit_q <= obit_d;
      osr_q <= osr_d;
      so_q <= so_d;
      oe_q <= oe_d;
      wel_q <= wel_d;
      busy_q <= busy_d;
      wcnt_q <= wcnt_d;
      pend_q <= pend_d;
      parr_q <= parr_d;
      wrok_q <= wrok_d;
    end
  end

  // Stands in for non-volatile cells: power-on reset leaves them alone
  always_ff @(posedge i_clk_sys or negedge i_factory_nrst) begin
    if (!i_factory_nrst) begin
      guard_q <= GUARD_FACTORY;
      pin_lock_enable_q <= PINLOCK_FACTORY;
    end else begin
      guard_q <= guard_d;
      pin_lock_enable_q <= pin_lock_enable_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < ARR_DEPTH; i++) mem_q[i] <= 8'h00;
    end else if (mem_we) begin
      mem_q[addr_q] <= wbyte_q;
    end
  end

  assign o_busy = busy_q;
  assign link.so = so_q;
  assign link.so_oe = oe_q;
endmodule
`default_nettype wire

// >>> hw/spi_ee_host.sv
`default_nettype none
module spi_ee_host (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic [spi_ee_pkg::BYTE_W-1:0] i_opcode,
  input wire logic [spi_ee_pkg::ADDR_W-1:0] i_addr,
  input wire logic [spi_ee_pkg::BYTE_W-1:0] i_wdata,
  input wire logic [spi_ee_pkg::BYTE_W-1:0] i_nbytes,
  output logic o_ready,
  output logic [spi_ee_pkg::BYTE_W-1:0] o_rdata,
  output logic o_rvalid,
  output logic o_done,
  spi_ee_if.host link
);
  import spi_ee_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TRAIL, H_GAP} hstate_t;

  hstate_t st_q, st_d;
  logic [1:0] div_q, div_d;
  logic [31:0] tx_q, tx_d;
  logic [11:0] bit_q, bit_d, tot_q, tot_d, hdr_q, hdr_d, rel;
  logic [7:0] rx_q, rx_d, op;
  logic rd_q, rd_d, cs_q, cs_d, sck_q, sck_d, si_q, si_d;
  logic rdy_q, rdy_d, rv_q, rv_d, done_q, done_d, tick;

  assign tick = (div_q == 2'h0);
  assign rel = bit_q - hdr_q;

  always_comb begin
    op = i_opcode & OPC_MASK;
    st_d = st_q;
    div_d = tick ? 2'(SCK_HALF_CLKS - 1) : div_q - 2'h1;
    tx_d = tx_q;
    bit_d = bit_q;
    tot_d = tot_q;
    hdr_d = hdr_q;
    rx_d = rx_q;
    rd_d = rd_q;
    cs_d = cs_q;
    sck_d = sck_q;
    si_d = si_q;
    rdy_d = rdy_q;
    rv_d = 1'b0;
    done_d = 1'b0;
    unique case (st_q)
      H_IDLE: begin
        div_d = 2'(SCK_HALF_CLKS - 1);
        if (i_start) begin
          hdr_d = HDR_OPC_BITS;
          tot_d = HDR_OPC_BITS;
          rd_d = 1'b0;
          tx_d = {op, i_wdata, 16'h0000};
          if (op == OPC_RDST) begin
            rd_d = 1'b1;
            tot_d = HDR_OPC_BITS + {1'b0, i_nbytes, 3'b000};
          end else if (op == OPC_RDARR) begin
            rd_d = 1'b1;
            hdr_d = HDR_ADDR_BITS;
            tot_d = HDR_ADDR_BITS + {1'b0, i_nbytes, 3'b000};
            tx_d = {op, i_addr, 8'h00};
          end else if (op == OPC_WRARR) begin
            tot_d = HDR_WRARR_BITS;
            tx_d = {op, i_addr, i_wdata};
          end else if (op == OPC_WRST) begin
            tot_d = HDR_WRST_BITS;
          end
          // Modifying frames rely on a set-latch frame sent before
          si_d = tx_d[31];
          tx_d = {tx_d[30:0], 1'b0};
          cs_d = 1'b0;
          bit_d = 12'h000;
          rdy_d = 1'b0;
          st_d = H_LOW;
        end
      end
      H_LOW: if (tick) begin
        sck_d = 1'b1;
        bit_d = bit_q + 12'h001;
        st_d = H_HIGH;
      end
      H_HIGH: if (tick) begin
        // Sampled late in the high phase to absorb the far end's sync delay
        rx_d = {rx_q[6:0], link.so};
        rv_d = rd_q && (bit_q > hdr_q) && (rel[2:0] == 3'h0);
        sck_d = 1'b0;
        if (bit_q == tot_q) begin
          st_d = H_TRAIL;
        end else begin
          si_d = tx_q[31];
          tx_d = {tx_q[30:0], 1'b0};
          st_d = H_LOW;
        end
      end
      H_TRAIL: if (tick) begin
        cs_d = 1'b1;
        st_d = H_GAP;
      end
      H_GAP: if (tick) begin
        done_d = 1'b1;
        rdy_d = 1'b1;
        st_d = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= H_IDLE;
      div_q <= 2'h0;
      tx_q <= 32'h00000000;
      bit_q <= 12'h000;
      tot_q <= 12'h000;
      hdr_q <= 12'h000;
      rx_q <= 8'h00;
      rd_q <= 1'b0;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      si_q <= 1'b0;
      rdy_q <= 1'b1;
      rv_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      tx_q <= tx_d;
      bit_q <= bit_d;
      tot_q <= tot_d;
      hdr_q <= hdr_d;
      rx_q <= rx_d;
      rd_q <= rd_d;
      cs_q <= cs_d;
      sck_q <= sck_d;
      si_q <= si_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
      done_q <= done_d;
    end
  end

  assign o_ready = rdy_q;
  assign o_rdata = rx_q;
  assign o_rvalid = rv_q;
  assign o_done = done_q;
  assign link.cs_n = cs_q;
  assign link.sck = sck_q;
  assign link.si = si_q;
endmodule
`default_nettype wire

// >>> hw/spi_ee_if.sv
`default_nettype none
interface spi_ee_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  modport host (output cs_n, output sck, output si, input so, input so_oe);
  modport dev (input cs_n, input sck, input si, output so, output so_oe);
endinterface
`default_nettype wire

// >>> hw/spi_ee_pkg.sv
`default_nettype none
package spi_ee_pkg;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam int ARR_AW = 11;
  localparam int ARR_DEPTH = 2048;
  localparam logic [7:0] OPC_MASK = 8'hf7;
  localparam logic [7:0] OPC_SETWL = 8'h06;
  localparam logic [7:0] OPC_CLRWL = 8'h04;
  localparam logic [7:0] OPC_RDST = 8'h05;
  localparam logic [7:0] OPC_WRST = 8'h01;
  localparam logic [7:0] OPC_RDARR = 8'h03;
  localparam logic [7:0] OPC_WRARR = 8'h02;
  localparam int ST_NRDY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_GUARD_LO = 2;
  localparam int ST_GUARD_HI = 3;
  localparam int ST_PINLOCK = 7;
  localparam logic [7:0] ST_BUSY_VAL = 8'hff;
  localparam logic [1:0] GUARD_FACTORY = 2'h0;
  localparam logic PINLOCK_FACTORY = 1'b0;
  localparam logic [10:0] GUARD_QTR_BASE = 11'h600;
  localparam logic [10:0] GUARD_HALF_BASE = 11'h400;
  localparam int CLK_PERIOD_NS = 20;
  localparam int WR_CYCLE_NS = 5000000;
  localparam int WR_CYCLE_CLKS = WR_CYCLE_NS / CLK_PERIOD_NS;
  localparam int SCK_PERIOD_NS = 160;
  localparam int SCK_HALF_CLKS = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [11:0] HDR_OPC_BITS = 12'h008;
  localparam logic [11:0] HDR_ADDR_BITS = 12'h018;
  localparam logic [11:0] HDR_WRST_BITS = 12'h010;
  localparam logic [11:0] HDR_WRARR_BITS = 12'h020;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_SETWL, CMD_CLRWL, CMD_RDST, CMD_WRST, CMD_RDARR, CMD_WRARR
  } cmd_t;
endpackage
`default_nettype wire
